// File: design/sfb_top.sv
// Flow-through burst memory: input registers, burst counter, write control, output drive
// Operation
// - Two-bit burst counter generates in-burst addresses
// - All synchronous inputs registered on rising edge
// - Order pin high interleaved, low linear
// - Either address strobe starts a burst
// - Address latched only when a strobe active
// - Following addresses advance only on advance input
// - Address taken on any accepted strobe, whatever the selects; selects gate only the access
// - Low two address bits load the counter
// - Lane written when lane select and qualifier
// - Global write writes all lanes
// - Output enable and sleep act unclocked
// - Burst timing two, one, one, one
// - Processor strobe ignored when first select high
// - Both strobes: processor strobe wins
// - Selects sampled only on new address
// - First read after deselect keeps outputs off
`timescale 1ns/100ps
`default_nettype none
module sfb_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Address and burst control
  input wire sfb_pkg::sfb_addr_t address,
  input wire logic burst_order_interleaved,
  input wire logic processor_address_strobe_n,
  input wire logic controller_address_strobe_n,
  input wire logic burst_advance_n,
  // Chip selects
  input wire logic pipeline_chip_select_n,
  input wire logic depth_select_high,
  input wire logic depth_select_low_n,
  // Write controls
  input wire logic byte_write_qualifier_n,
  input wire logic lane_a_write_select_n,
  input wire logic lane_b_write_select_n,
  input wire logic all_lanes_write_n,
  // Asynchronous controls
  input wire logic output_enable_n,
  input wire logic sleep_request,
  // Data pins
  input wire sfb_pkg::sfb_data_t data_in,
  output sfb_pkg::sfb_data_t data_out,
  output logic data_oe_n
);
  // Input registers
  sfb_pkg::sfb_addr_t addr_q;
  sfb_pkg::sfb_data_t wdata_q;
  logic mode_q, processor_address_strobe_n_n_q, controller_address_strobe_n_n_q, adv_n_q;
  logic ce1_n_q, ce2_q, ce3_n_q, bwe_n_q, bwa_n_q, bwb_n_q, gw_n_q;
  // Burst state
  logic [sfb_pkg::ADDR_W-1:sfb_pkg::BEAT_W] base_q;
  logic [sfb_pkg::BEAT_W-1:0] start_q, beat_q, beat_d, low_d;
  logic sel_q, drive_q;
  // Access decode
  logic p_take, c_take, new_load, sel_d, access, is_write;
  logic [sfb_pkg::LANES-1:0] wr_lane;
  sfb_pkg::sfb_addr_t acc_addr;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      processor_address_strobe_n_n_q <= 1'b1;
      controller_address_strobe_n_n_q <= 1'b1;
      adv_n_q <= 1'b1;
      ce1_n_q <= 1'b1;
      ce2_q <= 1'b0;
      ce3_n_q <= 1'b1;
      bwe_n_q <= 1'b1;
      bwa_n_q <= 1'b1;
      bwb_n_q <= 1'b1;
      gw_n_q <= 1'b1;
      mode_q <= 1'b0;
    end else begin
      processor_address_strobe_n_n_q <= processor_address_strobe_n;
      controller_address_strobe_n_n_q <= controller_address_strobe_n;
      adv_n_q <= burst_advance_n;
      ce1_n_q <= pipeline_chip_select_n;
      ce2_q <= depth_select_high;
      ce3_n_q <= depth_select_low_n;
      bwe_n_q <= byte_write_qualifier_n;
      bwa_n_q <= lane_a_write_select_n;
      bwb_n_q <= lane_b_write_select_n;
      gw_n_q <= all_lanes_write_n;
      mode_q <= burst_order_interleaved;
    end
  end

  // address and data capture, no reset needed on the data path
  always_ff @(posedge clk_sys) begin
    addr_q <= address;
    wdata_q <= data_in;
  end

  always_comb begin
    // processor strobe with first select low
    p_take = !processor_address_strobe_n_n_q && !ce1_n_q;
    c_take = !p_take && !controller_address_strobe_n_n_q;
    // either strobe loads a new address
    new_load = p_take || c_take;
    sel_d = !ce1_n_q && ce2_q && !ce3_n_q;
    // step only when advance sampled low
    beat_d = adv_n_q ? beat_q : beat_q + sfb_pkg::BEAT_STEP;
    // order select; xor or add, both modulo four
    low_d = mode_q ? (start_q ^ beat_d) : (start_q + beat_d);
    if (new_load) begin
      // external address used only on a strobe
      acc_addr = addr_q;
    end else begin
      // upper bits held, counter never carries
      acc_addr = {base_q, low_d};
    end
    // sleep blocks accesses without a clock
    access = (new_load ? sel_d : sel_q) && !sleep_request;
    if (!gw_n_q) begin
      wr_lane = sfb_pkg::LANES_ALL;
    end else if (!bwe_n_q) begin
      // lane select qualified by byte write
      wr_lane = {!bwb_n_q, !bwa_n_q};
    end else begin
      wr_lane = sfb_pkg::LANES_NONE;
    end
    // Processor-started cycles are always reads; write controls apply from the next beat
    if (p_take || !access) begin
      wr_lane = sfb_pkg::LANES_NONE;
    end
    is_write = wr_lane != sfb_pkg::LANES_NONE;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      base_q <= '0;
      start_q <= sfb_pkg::BEAT_RESET;
      beat_q <= sfb_pkg::BEAT_RESET;
    end else if (new_load) begin
      base_q <= addr_q[sfb_pkg::ADDR_W-1:sfb_pkg::BEAT_W];
      start_q <= addr_q[sfb_pkg::BEAT_W-1:0];
      beat_q <= sfb_pkg::BEAT_RESET;
    end else begin
      beat_q <= beat_d;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sel_q <= 1'b0;
    end else if (new_load) begin
      sel_q <= sel_d;
    end
  end

  // drive only once read data is present, so a read after deselect stays off first
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= access && !is_write;
    end
  end

  // flow-through read lands one edge after the registered request
  sfb_mem u_mem (
    .clk_sys(clk_sys),
    .addr(acc_addr),
    .rd_en(access && !is_write),
    .wr_lane(wr_lane),
    .wdata(wdata_q),
    .rdata_q(data_out)
  );

  // enable is combinational from the async pins; a register here would break async control
  assign data_oe_n = !(drive_q && !output_enable_n && !sleep_request);

  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence read_request_s;
    !processor_address_strobe_n && !pipeline_chip_select_n && depth_select_high && !depth_select_low_n;
  endsequence
  sequence read_request_quiet_s;
    read_request_s ##1 !sleep_request;
  endsequence
  sequence deselect_request_s;
    !controller_address_strobe_n && processor_address_strobe_n &&
      !(!pipeline_chip_select_n && depth_select_high && !depth_select_low_n);
  endsequence

  first_data_time_a: assert property (read_request_quiet_s |=> drive_q)
    else $error("first beat not ready two clocks after strobe");
  load_needs_strobe_a: assert property (new_load |-> (!processor_address_strobe_n_n_q || !controller_address_strobe_n_n_q))
    else $error("address loaded without strobe");
  proc_ignored_a: assert property ((ce1_n_q && controller_address_strobe_n_n_q) |-> !new_load)
    else $error("processor strobe taken with first select high");
  proc_priority_a: assert property ((!processor_address_strobe_n_n_q && !ce1_n_q) |-> !c_take)
    else $error("controller strobe taken over processor strobe");
  select_hold_a: assert property (!new_load |=> sel_q == $past(sel_q))
    else $error("selection changed during internal beat");
  interleave_order_a: assert property ((!new_load && mode_q) |-> acc_addr[1:0] == (start_q ^ beat_d))
    else $error("interleaved address wrong");
  linear_order_a: assert property ((!new_load && !mode_q) |-> acc_addr[1:0] == start_q + beat_d)
    else $error("linear address wrong");
  burst_wrap_a: assert property (!new_load |-> acc_addr[sfb_pkg::ADDR_W-1:2] == base_q)
    else $error("burst carried into upper address");
  hold_beat_a: assert property ((!new_load && adv_n_q) |=> beat_q == $past(beat_q))
    else $error("counter moved without advance");
  global_write_a: assert property ((access && !p_take && !gw_n_q) |-> wr_lane == sfb_pkg::LANES_ALL)
    else $error("global write missed a lane");
  lane_write_a: assert property ((access && !p_take && gw_n_q) |-> wr_lane == ({!bwb_n_q, !bwa_n_q} & {2{!bwe_n_q}}))
    else $error("lane write mismatch");
  seed_load_a: assert property (new_load |=> start_q == $past(addr_q[1:0]) && beat_q == 2'h0)
    else $error("counter not seeded from address");
  deselect_no_drive_a: assert property (deselect_request_s |=> ##1 !drive_q)
    else $error("deselected access drove the outputs");
  cold_read_off_a: assert property ((new_load && !sel_q) |-> data_oe_n)
    else $error("outputs driven on first clock after deselect");
  sleep_no_write_a: assert property (sleep_request |-> wr_lane == sfb_pkg::LANES_NONE)
    else $error("write accepted during sleep");
endmodule
`default_nettype wire

// File: design/sfb_pkg.sv
// Shared constants for the synchronous flow-through burst memory
package sfb_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int BEAT_W = 2;
  localparam int DEPTH = 524288;
  localparam int CLK_PERIOD_NS = 50;
  localparam int FIRST_DATA_CLKS = 2;
  localparam logic [BEAT_W-1:0] BEAT_RESET = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_STEP = 2'h1;
  localparam logic [LANES-1:0] LANES_NONE = 2'h0;
  localparam logic [LANES-1:0] LANES_ALL = 2'h3;
  typedef logic [ADDR_W-1:0] sfb_addr_t;
  typedef logic [DATA_W-1:0] sfb_data_t;
endpackage

// File: design/sfb_mem.sv
// Memory array with lane write enables and registered read data
`timescale 1ns/100ps
`default_nettype none
module sfb_mem (
  // Clock
  input wire logic clk_sys,
  // Access
  input wire sfb_pkg::sfb_addr_t addr,
  input wire logic rd_en,
  input wire logic [sfb_pkg::LANES-1:0] wr_lane,
  input wire sfb_pkg::sfb_data_t wdata,
  // Read data
  output sfb_pkg::sfb_data_t rdata_q
);
  sfb_pkg::sfb_data_t mem [sfb_pkg::DEPTH];

  // Contents carry no reset, so sleep and reset both preserve data
  always_ff @(posedge clk_sys) begin
    for (int l = 0; l < sfb_pkg::LANES; l++) begin
      if (wr_lane[l]) begin
        mem[addr][l*sfb_pkg::LANE_W +: sfb_pkg::LANE_W] <= wdata[l*sfb_pkg::LANE_W +: sfb_pkg::LANE_W];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rd_en) begin
      rdata_q <= mem[addr];
    end
  end
endmodule
`default_nettype wire

// File: sim/sfb_host.sv
// Bus master model that drives every input pin of the burst memory except clock and reset
`timescale 1ns/100ps
`default_nettype none
module sfb_host (
  // Clock
  input wire logic clk_sys,
  // Strobes, advance, selects, write controls, order, enable, sleep
  output logic [12:0] ctl,
  // Address and write data
  output sfb_pkg::sfb_addr_t address,
  output sfb_pkg::sfb_data_t data_in
);
  task automatic put(input logic [1:0] strb_n, input logic adv_n, input logic [2:0] sel, input logic [3:0] wr_n,
                     input sfb_pkg::sfb_addr_t a, input sfb_pkg::sfb_data_t d);
    @(negedge clk_sys);
    ctl[12:3] = {strb_n, adv_n, sel, wr_n};
    address = a;
    data_in = d;
  endtask
  // Levels, so they may move between edges
  task automatic set_lvl(input logic [2:0] lvl);
    ctl[2:0] = lvl;
  endtask
  initial begin
    ctl = 13'h1D78;
    address = '0;
    data_in = '0;
  end
endmodule
`default_nettype wire

// File: sim/sfb_top_tb_top.sv
// Self-checking bench for the flow-through burst memory
`timescale 1ns/100ps
`default_nettype none
module sfb_top_tb_top;
  typedef struct {int at; logic chk_d; sfb_pkg::sfb_data_t d; logic oe_n;} sfb_exp_s;
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  logic [12:0] ctl;
  logic data_oe_n;
  sfb_pkg::sfb_addr_t address, g;
  sfb_pkg::sfb_data_t data_in, data_out;
  sfb_pkg::sfb_data_t mem [sfb_pkg::sfb_addr_t];
  sfb_exp_s expq[$];
  int ecnt = 0;
  int bad_count = 0;
  int num_checks = 0;
  logic [31:0] rng = 32'h00004187;
  sfb_host u_host (.clk_sys, .ctl, .address, .data_in);
  sfb_top u_dut (.clk_sys, .resetn, .address, .burst_order_interleaved(ctl[2]),
    .processor_address_strobe_n(ctl[12]), .controller_address_strobe_n(ctl[11]), .burst_advance_n(ctl[10]),
    .pipeline_chip_select_n(ctl[9]), .depth_select_high(ctl[8]), .depth_select_low_n(ctl[7]),
    .byte_write_qualifier_n(ctl[5]), .lane_a_write_select_n(ctl[3]), .lane_b_write_select_n(ctl[4]),
    .all_lanes_write_n(ctl[6]), .output_enable_n(ctl[1]), .sleep_request(ctl[0]), .data_in, .data_out, .data_oe_n);
  always #(sfb_pkg::CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
  always @(posedge clk_sys) ecnt <= ecnt + 1;
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Falling edge sees settled outputs; each note names its edge count
  always @(negedge clk_sys) begin
    while (expq.size() > 0 && expq[0].at <= ecnt) begin
      check(data_oe_n, expq[0].oe_n);
      if (expq[0].chk_d) check(data_out, expq[0].d);
      void'(expq.pop_front());
    end
  end
  task automatic wr(input sfb_pkg::sfb_addr_t a, input logic [3:0] w, input sfb_pkg::sfb_data_t d);
    sfb_pkg::sfb_data_t m;
    m = mem.exists(a) ? mem[a] : 'x;
    u_host.put(2'h2, 1'h1, 3'h2, w, a, d);
    if (!w[3]) m = d;
    else if (!w[2]) begin
      if (!w[0]) m[sfb_pkg::LANE_W-1:0] = d[sfb_pkg::LANE_W-1:0];
      if (!w[1]) m[sfb_pkg::DATA_W-1:sfb_pkg::LANE_W] = d[sfb_pkg::DATA_W-1:sfb_pkg::LANE_W];
    end
    mem[a] = m;
    u_host.put(2'h3, 1'h1, 3'h2, 4'hF, a, ~d);
  endtask
  task automatic rd(input logic [1:0] s, input logic il, input sfb_pkg::sfb_addr_t a, input int hold, input logic cold);
    logic [1:0] b;
    int k;
    u_host.put(s, 1'h1, 3'h2, 4'hF, a, 18'(xs()));
    u_host.set_lvl({il, 2'h0});
    k = ecnt;
    if (cold) expq.push_back('{k + 1, 1'h0, 18'h0, 1'h1});
    if (hold > 0) expq.push_back('{k + sfb_pkg::FIRST_DATA_CLKS, 1'h1, mem[a], 1'h0});
    for (int i = 0; i < 4; i++) begin
      b = il ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i);
      expq.push_back('{k + sfb_pkg::FIRST_DATA_CLKS + hold + i, 1'h1, mem[{a[sfb_pkg::ADDR_W-1:2], b}], 1'h0});
    end
    repeat (hold) u_host.put(2'h3, 1'h1, 3'h2, 4'hF, a, 18'(xs()));
    repeat (3) u_host.put(2'h3, 1'h0, 3'h2, 4'hF, a, 18'(xs()));
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'h1;
    g = 19'(xs());
    g[1:0] = 2'h0;
    for (int i = 0; i < 4; i++) wr(g + 19'(i), 4'h7, 18'(xs()));
    rd(2'h2, 1'h0, g + 19'h2, 0, 1'h0);
    rd(2'h1, 1'h1, g + 19'h1, 0, 1'h0);
    wr(g, 4'hA, 18'(xs()));
    wr(g + 19'h1, 4'hD, 18'(xs()));
    wr(g + 19'h3, 4'h9, 18'(xs()));
    u_host.put(2'h0, 1'h1, 3'h2, 4'h7, g + 19'h2, 18'(xs()));
    expq.push_back('{ecnt + 2, 1'h1, mem[g + 19'h2], 1'h0});
    u_host.put(2'h3, 1'h1, 3'h2, 4'hF, g, 18'(xs()));
    // first select high: strobe ignored, open burst keeps driving
    u_host.put(2'h1, 1'h1, 3'h6, 4'hF, g, 18'(xs()));
    expq.push_back('{ecnt + 2, 1'h1, mem[g + 19'h2], 1'h0});
    u_host.put(2'h2, 1'h1, 3'h0, 4'h7, g + 19'h3, 18'(xs()));
    expq.push_back('{ecnt + 2, 1'h0, 18'h0, 1'h1});
    rd(2'h1, 1'h0, g, 1, 1'h1);
    for (int n = 0; n < 20 && expq.size() > 0; n++) @(negedge clk_sys);
    if (expq.size() > 0) bad_count++;
    u_host.set_lvl(3'h2);
    #1 check(data_oe_n, 1'h1);
    u_host.set_lvl(3'h0);
    #1 check(data_oe_n, 1'h0);
    u_host.set_lvl(3'h1);
    #1 check(data_oe_n, 1'h1);
    close_out();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
